// [hw/seepi_core.sv]
// serial front end of a small spi nonvolatile memory, sampled by sys_clk
`timescale 1ns/1ps
module seepi_core
    import seepi_pkg::*;
#(
    parameter int unsigned PROGRAM_CYC = PROGRAM_CYCLES,
    parameter int unsigned FIFO_DEPTH  = 16
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // serial pins
    input  wire logic         serial_clk,
    input  wire logic         device_select_n,
    input  wire logic         serial_in,
    output logic              serial_out,
    output logic              serial_out_oe,
    input  wire logic         pause_n,
    input  wire logic         write_guard_n,
    // array side: write words out, read bytes in
    output logic              wr_valid,
    input  wire logic         wr_ready,
    output seepi_wword_s      wr_word,
    output logic              rd_req,
    output logic [15:0]       rd_addr,
    input  wire logic [7:0]   rd_data,
    // program cycle and status
    output logic              program_start,
    output logic              program_busy,
    output logic              standby,
    output logic [7:0]        status
);
    seepi_pins_s  meta_q, sync_q, prev_q;
    seepi_state_e state_q, state_d;
    logic [2:0]   bit_q, bit_d;
    logic [7:0]   shin_q, shin_d, shout_q, shout_d;
    logic [15:0]  addr_q, addr_d;
    logic [4:0]   abytes_q, abytes_d;
    logic [7:0]   op_q, op_d;
    logic         latch_q, latch_d, gpen_q, gpen_d, bhi_q, bhi_d, blo_q, blo_d;
    logic         arm_q, arm_d, so_q, so_d, oe_q, oe_d;
    logic [31:0]  prog_q, prog_d;
    logic         busy_q, busy_d, start_q, start_d;
    logic         push_valid, push_ready;
    seepi_wword_s push_word;
    logic         rise, fall, sel_fall, sel_rise, active;
    logic [7:0]   byte_in, stat_now;

    // two-stage synchronisers; first stage read only by the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            sync_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            prev_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        end else begin
            meta_q <= '{serial_clk, device_select_n, serial_in, pause_n, write_guard_n};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // sck edges ignored while paused; host keeps sck low around pause changes
    assign active   = !sync_q.sel_n && sync_q.pause_n;
    assign rise     = active && sync_q.sck && !prev_q.sck;
    assign fall     = active && !sync_q.sck && prev_q.sck;
    assign sel_fall = prev_q.sel_n && !sync_q.sel_n;
    assign sel_rise = !prev_q.sel_n && sync_q.sel_n;
    assign byte_in  = {shin_q[6:0], sync_q.sin};
    assign stat_now = {gpen_q, 3'h0, bhi_q, blo_q, latch_q, busy_q};

    function automatic logic guard_blocks(input logic gpen, input logic guard_n);
        return gpen && !guard_n;
    endfunction : guard_blocks

    always_comb begin
        state_d  = state_q;
        bit_d    = bit_q;
        shin_d   = shin_q;
        shout_d  = shout_q;
        addr_d   = addr_q;
        abytes_d = abytes_q;
        op_d     = op_q;
        latch_d  = latch_q;
        gpen_d   = gpen_q;
        bhi_d    = bhi_q;
        blo_d    = blo_q;
        arm_d    = arm_q;
        so_d     = so_q;
        push_valid = 1'b0;
        push_word  = '{addr_q, byte_in};
        rd_req     = 1'b0;
        if (sel_fall || sync_q.sel_n) begin
            // partial byte dropped, fresh opcode awaited
            state_d = SEEPI_OPCODE;
            bit_d   = '0;
            arm_d   = sel_fall ? 1'b0 : arm_q;
        end else if (rise) begin
            shin_d = byte_in;
            bit_d  = bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
                case (state_q)
                    SEEPI_OPCODE: begin
                        op_d     = byte_in;
                        abytes_d = '0;
                        state_d  = SEEPI_IGNORE;
                        if (byte_in == OP_STATUS_READ) begin
                            state_d = SEEPI_SRD;
                            shout_d = stat_now;
                        end else if (busy_q) begin
                            state_d = SEEPI_IGNORE;
                        end else if (byte_in == OP_LATCH_SET) begin
                            arm_d = 1'b1;
                        end else if (byte_in == OP_LATCH_CLR) begin
                            arm_d = 1'b1;
                        end else if (byte_in == OP_STATUS_WR) begin
                            state_d = SEEPI_SWR;
                        end else if (byte_in == OP_ARRAY_READ
                                  || byte_in == OP_ARRAY_WR) begin
                            state_d = SEEPI_ADDR;
                        end // others ignored
                    end
                    SEEPI_ADDR: begin
                        addr_d   = {addr_q[7:0], byte_in};
                        abytes_d = abytes_q + 5'h1;
                        if (abytes_q + 5'h1 == ADDR_BYTES) begin
                            if (op_q == OP_ARRAY_WR) begin
                                state_d = latch_q ? SEEPI_WDATA : SEEPI_IGNORE;
                            end else begin
                                state_d = SEEPI_RDATA;
                                addr_d  = {addr_q[7:0], byte_in};
                                rd_req  = 1'b1;
                            end
                        end
                    end
                    SEEPI_WDATA: begin
                        // a full buffer drops the byte rather than stall the host
                        push_valid = 1'b1;
                        addr_d     = addr_q + 16'h1;
                        arm_d      = push_ready ? 1'b1 : arm_q;
                    end
                    SEEPI_SWR: begin
                        if (latch_q && !guard_blocks(gpen_q, sync_q.guard_n)) begin
                            arm_d = 1'b1;
                            shin_d = byte_in;
                        end
                        state_d = SEEPI_IGNORE;
                    end
                    default: state_d = state_q;
                endcase
            end
        end else if (fall) begin
            // next bit shifted out on the falling edge
            so_d    = shout_q[7];
            shout_d = {shout_q[6:0], 1'b0};
            if (bit_q == '0 && state_q == SEEPI_SRD) begin
                so_d    = stat_now[7];
                shout_d = {stat_now[6:0], 1'b0};
            end else if (bit_q == '0 && state_q == SEEPI_RDATA) begin
                so_d    = rd_data[7];
                shout_d = {rd_data[6:0], 1'b0};
                addr_d  = addr_q + 16'h1;
                rd_req  = 1'b1;
            end
        end
        if (sel_rise && bit_q == '0 && arm_q) begin
            // commands act only when select closes on a byte boundary
            if (op_q == OP_LATCH_SET) begin
                latch_d = 1'b1;
            end else if (op_q == OP_LATCH_CLR) begin
                latch_d = 1'b0;
            end else if (op_q == OP_STATUS_WR
                      && !guard_blocks(gpen_q, sync_q.guard_n)) begin
                gpen_d  = shin_q[ST_GUARD_PIN_EN];
                bhi_d   = shin_q[ST_BLOCK_HI];
                blo_d   = shin_q[ST_BLOCK_LO];
                latch_d = 1'b0;
            end else if (op_q == OP_ARRAY_WR) begin
                latch_d = 1'b0;
            end
        end
    end

    // program timer: starts on the closing select, runs regardless of select
    always_comb begin
        start_d = sel_rise && bit_q == '0 && arm_q
               && (op_q == OP_STATUS_WR || op_q == OP_ARRAY_WR)
               && !(op_q == OP_STATUS_WR && guard_blocks(gpen_q, sync_q.guard_n));
        busy_d = busy_q;
        prog_d = prog_q;
        if (start_d) begin
            busy_d = 1'b1;
            prog_d = PROGRAM_CYC - 1;
        end else if (busy_q) begin
            if (prog_q == '0) begin
                busy_d = 1'b0;
            end else begin
                prog_d = prog_q - 32'h1;
            end
        end
        // output enable follows select and pause
        oe_d = !sync_q.sel_n && sync_q.pause_n;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q  <= SEEPI_OPCODE;
            bit_q    <= '0;
            shin_q   <= '0;
            shout_q  <= '0;
            addr_q   <= '0;
            abytes_q <= '0;
            op_q     <= '0;
            latch_q  <= ST_RESET[ST_WRITE_LATCH];
            gpen_q   <= ST_RESET[ST_GUARD_PIN_EN];
            bhi_q    <= ST_RESET[ST_BLOCK_HI];
            blo_q    <= ST_RESET[ST_BLOCK_LO];
            arm_q    <= 1'b0;
            so_q     <= 1'b0;
            oe_q     <= 1'b0;
            prog_q   <= '0;
            busy_q   <= 1'b0;
            start_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            bit_q    <= bit_d;
            shin_q   <= shin_d;
            shout_q  <= shout_d;
            addr_q   <= addr_d;
            abytes_q <= abytes_d;
            op_q     <= op_d;
            latch_q  <= latch_d;
            gpen_q   <= gpen_d;
            bhi_q    <= bhi_d;
            blo_q    <= blo_d;
            arm_q    <= arm_d;
            so_q     <= so_d;
            oe_q     <= oe_d;
            prog_q   <= prog_d;
            busy_q   <= busy_d;
            start_q  <= start_d;
        end
    end

    seepi_fifo #(
        .WIDTH ($bits(seepi_wword_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_wfifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

    assign serial_out    = so_q;
    assign serial_out_oe = oe_q;
    assign rd_addr       = addr_q;
    assign program_start = start_q;
    assign program_busy  = busy_q;
    assign standby       = sync_q.sel_n && !busy_q;
    assign status        = stat_now;

endmodule : seepi_core

// [hw/seepi_pkg.sv]
// package for the serial eeprom pin interface: opcodes, status layout, timing
package seepi_pkg;

    // clock and timing
    localparam int unsigned SYS_CLK_MHZ        = 100;
    localparam int unsigned PROGRAM_TIME_MS    = 5;
    localparam int unsigned PROGRAM_CYCLES     = PROGRAM_TIME_MS * 1000 * SYS_CLK_MHZ;
    localparam int unsigned POWER_UP_TIME_MS   = 1;
    localparam int unsigned POWER_UP_CYCLES    = POWER_UP_TIME_MS * 1000 * SYS_CLK_MHZ;

    // opcodes
    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR   = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WR   = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ  = 8'h03;
    localparam logic [7:0] OP_ARRAY_WR    = 8'h02;

    // status register bit positions
    localparam int unsigned ST_GUARD_PIN_EN = 7;
    localparam int unsigned ST_BLOCK_HI     = 3;
    localparam int unsigned ST_BLOCK_LO     = 2;
    localparam int unsigned ST_WRITE_LATCH  = 1;
    localparam int unsigned ST_WIP          = 0;
    localparam logic [7:0]  ST_RESET        = 8'h00;

    // frame widths
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned ADDR_BITS = 16;
    localparam logic [2:0]  BIT_LAST  = 3'h7;
    localparam logic [4:0]  ADDR_BYTES = 5'h02;

    typedef enum logic [2:0] {
        SEEPI_OPCODE = 3'b000,
        SEEPI_ADDR   = 3'b001,
        SEEPI_WDATA  = 3'b010,
        SEEPI_RDATA  = 3'b011,
        SEEPI_SWR    = 3'b100,
        SEEPI_SRD    = 3'b101,
        SEEPI_IGNORE = 3'b110
    } seepi_state_e;

    // synchronised pin samples
    typedef struct packed {
        logic sck;
        logic sel_n;
        logic sin;
        logic pause_n;
        logic guard_n;
    } seepi_pins_s;

    // one word handed to the array side
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } seepi_wword_s;

endpackage : seepi_pkg

// [hw/seepi_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module seepi_fifo
    import seepi_pkg::*;
#(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // fill side
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic [WIDTH-1:0]  in_data,
    // drain side
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [WIDTH-1:0]       out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop  ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule : seepi_fifo

// [verification/seepi_props.sv]
// concurrent checks on the serial front end ports
`timescale 1ns/1ps
module seepi_props
    import seepi_pkg::*;
#(
    parameter int unsigned PROGRAM_CYC = PROGRAM_CYCLES
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // serial pins
    input wire logic       serial_clk,
    input wire logic       device_select_n,
    input wire logic       pause_n,
    input wire logic       write_guard_n,
    input wire logic       serial_out,
    input wire logic       serial_out_oe,
    // array side and status
    input wire logic       wr_valid,
    input wire logic       wr_ready,
    input wire logic       program_start,
    input wire logic       program_busy,
    input wire logic       standby,
    input wire logic [7:0] status
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // a counter, because the program cycle is far beyond a repetition count
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    always_comb busy_cnt_d = program_busy ? busy_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) busy_cnt_q <= 32'h0;
        else busy_cnt_q <= busy_cnt_d;
    end
    sel_hiz_a: assert property (device_select_n [*5] |-> !serial_out_oe)
        else $error("serial_out driven while deselected");
    pause_hiz_a: assert property (!pause_n [*5] |-> !serial_out_oe)
        else $error("serial_out driven while paused");
    idle_standby_a: assert property (device_select_n [*4] ##0 !program_busy |-> standby)
        else $error("no standby while deselected and idle");
    busy_awake_a: assert property (program_busy |-> !standby)
        else $error("standby during program cycle");
    start_busy_a: assert property (program_start |=> program_busy)
        else $error("program start without busy");
    busy_len_a: assert property (busy_cnt_q <= PROGRAM_CYC)
        else $error("program cycle too long");
    busy_full_a: assert property ($fell(program_busy) |-> busy_cnt_q == PROGRAM_CYC)
        else $error("program cycle ended early");
    wip_mirror_a: assert property (status[ST_WIP] == program_busy)
        else $error("busy bit differs from program state");
    zero_bits_a: assert property (status[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    so_fall_a: assert property ($changed(serial_out) && serial_out_oe && $past(serial_out_oe)
        |-> !$past(serial_clk, 2)) else $error("serial_out moved away from a falling edge");
    guard_hold_a: assert property ((!write_guard_n) [*5] ##0 status[ST_GUARD_PIN_EN]
        |=> $stable(status[7:2])) else $error("guarded status changed");
    cover property (program_start);
    cover property ($rose(serial_out_oe));
    cover property (wr_valid && wr_ready);
endmodule : seepi_props

// [verification/seepi_host.sv]
// host spi controller model driving the serial pins
`timescale 1ns/1ps
module seepi_host (
    // clock
    input wire logic sys_clk,
    // serial pins
    output logic     serial_clk,
    output logic     device_select_n,
    output logic     serial_in,
    output logic     pause_n,
    output logic     write_guard_n,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic cpol = 1'b0;
    logic oe_held;
    wire  so_wire;
    // no pull on the line: a released output shows the inverse, never the last bit
    assign so_wire = serial_out_oe ? serial_out : ~serial_out;
    initial begin
        serial_clk = 1'b0;
        device_select_n = 1'b1;
        serial_in = 1'b0;
        pause_n = 1'b1;
        write_guard_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic open_s();
        serial_clk <= cpol;
        device_select_n <= 1'b0;
        tick(8);
    endtask : open_s
    task automatic close_s();
        serial_clk <= cpol;
        tick(8);
        device_select_n <= 1'b1;
        serial_in <= ~serial_in; // released line must not keep its last level
        tick(8);
    endtask : close_s
    // nbits below 8 leaves a partial byte; hold_at pauses before that bit
    task automatic xfer(input logic [7:0] tx, input int nbits, input int hold_at,
                        output logic [7:0] rx);
        for (int i = 0; i < nbits; i++) begin
            serial_clk <= 1'b0;
            serial_in <= tx[7-i];
            tick(8);
            if (i == hold_at) begin
                pause_n <= 1'b0;
                tick(8);
                oe_held = serial_out_oe;
                serial_clk <= 1'b1; // stray edge the device must ignore
                tick(8);
                serial_clk <= 1'b0;
                tick(8);
                pause_n <= 1'b1;
                tick(8);
            end
            serial_clk <= 1'b1;
            rx[7-i] = so_wire;
            tick(8);
        end
    endtask : xfer
endmodule : seepi_host

// [verification/tb.sv]
// self-checking bench for the serial front end
`timescale 1ns/1ps
module tb;
    import seepi_pkg::*;
    logic         sys_clk, rst, wr_ready, wr_valid, rd_req, program_start, program_busy, standby;
    logic         serial_clk, device_select_n, serial_in, pause_n, write_guard_n;
    logic         serial_out, serial_out_oe;
    seepi_wword_s wr_word;
    logic [15:0]  rd_addr;
    logic [7:0]   rd_data, status;
    int           n_tests, bad_count, starts, cyc, reads;
    assign rd_data = rd_addr[7:0] ^ 8'h5a;
    seepi_core #(.PROGRAM_CYC(200)) dut (.sys_clk(sys_clk), .rst(rst), .serial_clk(serial_clk),
        .device_select_n(device_select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .pause_n(pause_n), .write_guard_n(write_guard_n),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .program_start(program_start),
        .program_busy(program_busy), .standby(standby), .status(status));
    seepi_host host (.sys_clk(sys_clk), .serial_clk(serial_clk),
        .device_select_n(device_select_n), .serial_in(serial_in), .pause_n(pause_n),
        .write_guard_n(write_guard_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (program_start === 1'b1) starts <= starts + 1;
    always @(posedge sys_clk) if (rd_req === 1'b1) reads <= reads + 1;
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic send(input logic [39:0] w, input int n);
        logic [7:0] r;
        host.open_s();
        for (int i = 0; i < n; i++) host.xfer(w[39-8*i -: 8], 8, 99, r);
        host.close_s();
    endtask : send
    task automatic wait_idle();
        for (int k = 0; k < 400 && program_busy !== 1'b0; k++) @(posedge sys_clk);
        chk("idle", 0, program_busy);
    endtask : wait_idle
    task automatic wr_stat(input logic [7:0] v);
        send({OP_LATCH_SET, 32'h0}, 1);
        send({OP_STATUS_WR, v, 24'h0}, 2);
        wait_idle();
    endtask : wr_stat
    task automatic t_fill();
        logic [7:0] r;
        int s0;
        s0 = starts;
        send({OP_LATCH_SET, 32'h0}, 1);
        chk("write_latch", 1, status[ST_WRITE_LATCH]);
        host.open_s();
        for (int i = 0; i < 20; i++)
            host.xfer(i == 0 ? OP_ARRAY_WR : i == 1 ? 8'h01 : i == 2 ? 8'h20 : 8'(i + 8'h2d), 8, 99, r);
        host.close_s();
        chk("program start", 24'(s0 + 1), 24'(starts));
        chk("busy bit", 1, status[ST_WIP]);
        chk("standby while busy", 0, standby);
        send({OP_LATCH_SET, 32'h0}, 1);
        wait_idle();
        chk("status after write", 8'h00, status);
        chk("standby", 1, standby);
        @(posedge sys_clk) wr_ready <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            chk("fifo word", {16'h0120 + 16'(k), 8'h30 + 8'(k)}, wr_word);
            @(posedge sys_clk);
            #1;
        end
        chk("fifo empty", 0, wr_valid);
        @(posedge sys_clk) wr_ready <= 1'b0;
        $display("test fill done");
    endtask : t_fill
    task automatic t_guard();
        wr_stat(8'h8c);
        chk("status guard high", 8'h8c, status);
        @(posedge sys_clk) host.write_guard_n <= 1'b0;
        wr_stat(8'h00);
        chk("status guarded", 6'h23, status[7:2]);
        @(posedge sys_clk) host.write_guard_n <= 1'b1;
        wr_stat(8'h0c);
        chk("status unguarded", 8'h0c, status);
        $display("test guard done");
    endtask : t_guard
    task automatic t_read();
        logic [7:0] r;
        host.cpol = 1'b1;
        @(posedge sys_clk) host.serial_clk <= 1'b1;
        host.tick(8);
        host.open_s();
        host.xfer(OP_STATUS_READ, 8, 99, r);
        host.xfer(8'h00, 8, 3, r);
        host.close_s();
        chk("status serial paused", 8'h0c, r);
        chk("oe in pause", 0, host.oe_held);
        chk("oe deselected", 0, serial_out_oe);
        host.open_s();
        for (int i = 0; i < 5; i++) begin
            host.xfer(i == 0 ? OP_ARRAY_READ : i == 2 ? 8'h40 : 8'h00, 8, 99, r);
            if (i > 2) chk("array byte", {16'h0, 8'h1a + 8'(i - 3)}, r);
        end
        host.close_s();
        chk("read address", 24'h000042, {8'h00, rd_addr});
        chk("read requests", 24'h1, 24'(reads >= 2));
        host.cpol = 1'b0;
        @(posedge sys_clk) host.serial_clk <= 1'b0;
        $display("test read done");
    endtask : t_read
    task automatic t_refuse();
        logic [7:0] r;
        send({OP_LATCH_SET, 32'h0}, 1);
        host.open_s();
        host.xfer(OP_LATCH_CLR, 4, 99, r);
        host.close_s();
        send({8'h66, 32'h0}, 1);
        chk("partial then bad code", 1, status[ST_WRITE_LATCH]);
        send({OP_LATCH_SET, 32'h0}, 1);
        chk("latch set", 1, status[ST_WRITE_LATCH]);
        send({OP_LATCH_CLR, 32'h0}, 1);
        chk("latch clear", 0, status[ST_WRITE_LATCH]);
        host.open_s();
        host.xfer(OP_STATUS_READ, 8, 99, r);
        host.xfer(8'h00, 8, 99, r);
        host.close_s();
        chk("status serial", 8'h0c, r);
        $display("test refuse done");
    endtask : t_refuse
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    initial begin
        cyc = 0;
        forever begin
            @(posedge sys_clk);
            cyc++;
            if (cyc == 20000) begin
                bad_count++;
                close_out();
            end
        end
    end
    initial begin
        rst = 1'b1;
        wr_ready = 1'b0;
        n_tests = 0;
        bad_count = 0;
        starts = 0;
        reads = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        host.tick(16); // shortened power-up wait
        t_fill();
        t_guard();
        t_read();
        t_refuse();
        close_out();
    end
endmodule : tb
bind seepi_core seepi_props #(.PROGRAM_CYC(PROGRAM_CYC)) u_props (.sys_clk(sys_clk),
    .rst(rst), .serial_clk(serial_clk), .device_select_n(device_select_n), .pause_n(pause_n),
    .write_guard_n(write_guard_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .program_start(program_start),
    .program_busy(program_busy), .standby(standby), .status(status));
